// file: logic/spdc_pkg.sv
// shared constants, field layouts and types of the sleep power-down controller
package spdc_pkg;
  // wishbone geometry
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int REG_W = 8;
  // register byte offsets
  localparam logic [WB_AW-1:0] OFS_INTCTL = 8'h00;
  localparam logic [WB_AW-1:0] OFS_OPTION = 8'h04;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_ENABLE_1 = 8'h08;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_ENABLE_2 = 8'h0c;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_ENABLE_3 = 8'h10;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_REQUEST_1 = 8'h14;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_REQUEST_2 = 8'h18;
  localparam logic [WB_AW-1:0] OFS_PERIPH_IRQ_REQUEST_3 = 8'h1c;
  localparam logic [WB_AW-1:0] OFS_REGCTL = 8'h20;
  localparam logic [WB_AW-1:0] OFS_STATUS = 8'h24;
  localparam logic [WB_AW-1:0] OFS_SLPCFG = 8'h28;
  // reset values
  localparam logic [REG_W-1:0] RST_INTCTL = 8'h00;
  localparam logic [REG_W-1:0] RST_OPTION = 8'hff;
  localparam logic [REG_W-1:0] RST_PIE = 8'h00;
  localparam logic [REG_W-1:0] RST_PIR = 8'h00;
  localparam logic [REG_W-1:0] RST_REGCTL = 8'h01;
  localparam logic [REG_W-1:0] RST_SLPCFG = 8'h00;
  // interrupt_control field positions
  localparam int INT_GIE = 7;
  localparam int INT_PEIE = 6;
  localparam int INT_TMR0IE = 5;
  localparam int INT_INTE = 4;
  localparam int INT_IOCIE = 3;
  localparam int INT_TMR0IF = 2;
  localparam int INT_INTF = 1;
  localparam int INT_IOCIF = 0;
  // regulator_control and status field positions
  localparam int REG_LP_BIT = 1;
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  // implemented bits of the peripheral enable and request registers and of regulator_control
  localparam logic [REG_W-1:0] PERIPH_IRQ_REQUEST_1_MASK = 8'hcb;
  localparam logic [REG_W-1:0] PERIPH_IRQ_REQUEST_2_MASK = 8'h6c;
  localparam logic [REG_W-1:0] PERIPH_IRQ_REQUEST_3_MASK = 8'h03;
  localparam logic [REG_W-1:0] REGCTL_MASK = 8'h03;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // watchdog operating modes, encoded as the configuration field
  typedef enum logic [1:0] {WDT_OFF = 2'b00, WDT_SW = 2'b01, WDT_NOT_SLEEP = 2'b10, WDT_ON = 2'b11} spdc_wdt_mode_t;
  // timer1 clock source selection
  typedef enum logic [1:0] {T1_FOSC4 = 2'b00, T1_FOSC = 2'b01, T1_PIN = 2'b10, T1_LFOSC = 2'b11} spdc_t1src_t;
  // sleep configuration register layout, msb first
  typedef struct packed {
    logic lp_blocker;
    logic hfosc_user;
    logic adc_rc_sel;
    spdc_t1src_t t1_src;
    logic sw_wdt_en;
    spdc_wdt_mode_t wdt_mode;
  } spdc_slpcfg_t;
  // power state of the controller
  typedef enum logic [1:0] {ST_AWAKE, ST_ASLEEP, ST_SETTLE, ST_RESUME} spdc_state_t;
endpackage

// file: logic/spdc_sleep_ctrl.sv
// sleep power-down controller with wishbone register slave
// Behaviour
// - sleep entered only by core sleep instruction
// - clear watchdog on entry, keep counting if enabled
// - entry clears powerdown flag, sets timeout flag
// - core clock stopped while asleep
// - low frequency oscillator keeps running in sleep
// - timer1 runs in sleep on pin/lf clock
// - adc runs in sleep with rc clock
// - io holds state, other resets still work
// - pin/brownout reset fully, others wake and continue
// - core prefetches next instruction during sleep
// - wake needs own enable, ignores global enable
// - global enable decides resume or vector after
// - watchdog cleared on every wake-up
// - pending irq before sleep with global enable off makes it a no-op
// - irq during sleep wakes at once, flags updated
// - low power select puts regulator low in sleep
// - low power sleep adds settle delay on wake
// - incompatible active peripheral keeps regulator normal
// - high freq oscillator may run for its users
// - unregulated variant: no low power select, no delay
// - low power select is regulator_control bit 1
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module spdc_sleep_ctrl
  import spdc_pkg::*;
#(
  parameter bit REGULATED = 1'b1,
  parameter int SETTLE_CNT = SETTLE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [WB_AW-1:0] I_WB_ADR,
  input wire logic [WB_DW-1:0] I_WB_DAT,
  input wire logic [3:0] I_WB_SEL,
  output logic [WB_DW-1:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_SLEEP_EXEC,
  input wire logic I_TMR0_OVF,
  input wire logic I_EXT_INT,
  input wire logic I_IOC_EVT,
  input wire logic [REG_W-1:0] I_PERIPH_IRQ_REQUEST_1_SET,
  input wire logic [REG_W-1:0] I_PERIPH_IRQ_REQUEST_2_SET,
  input wire logic [REG_W-1:0] I_PERIPH_IRQ_REQUEST_3_SET,
  input wire logic I_MASTER_CLEAR_PIN_N,
  input wire logic I_BROWNOUT_RESET,
  input wire logic I_WDT_TIMEOUT,
  output logic O_CORE_CLK_EN,
  output logic O_PREFETCH_NEXT,
  output logic O_RESUME,
  output logic O_VECTOR_IRQ,
  output logic O_FULL_RESET,
  output logic O_WDT_CLEAR,
  output logic O_WDT_RUN,
  output logic O_LFOSC_RUN,
  output logic O_HFOSC_RUN,
  output logic O_TIMER1_RUN,
  output logic O_ADC_RUN,
  output logic O_IO_HOLD,
  output logic O_REG_LOW_POWER
);

  localparam int CW = $clog2(SETTLE_CNT + 1);
  localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CNT - 1);

  // any interrupt with enable and flag set; global enable plays no part here
  function automatic logic irq_pending(input logic [REG_W-1:0] ic, input logic [REG_W-1:0] e1,
                                       input logic [REG_W-1:0] e2, input logic [REG_W-1:0] e3,
                                       input logic [REG_W-1:0] r1, input logic [REG_W-1:0] r2,
                                       input logic [REG_W-1:0] r3);
    logic core_irq;
    logic per_irq;
    core_irq = (ic[INT_TMR0IE] & ic[INT_TMR0IF]) | (ic[INT_INTE] & ic[INT_INTF]) | (ic[INT_IOCIE] & ic[INT_IOCIF]);
    per_irq = ic[INT_PEIE] & (|(e1 & r1) | |(e2 & r2) | |(e3 & r3));
    return core_irq | per_irq;
  endfunction

  // decoded write strobe for one register offset
  function automatic logic wr_hit(input logic fire, input logic [WB_AW-1:0] adr, input logic [WB_AW-1:0] ofs);
    return fire && (adr[WB_AW-1:2] == ofs[WB_AW-1:2]);
  endfunction

  logic ack_r;
  logic wr_fire;
  logic [REG_W-1:0] rd_byte;
  logic [REG_W-1:0] intctl_r;
  logic [REG_W-1:0] option_r;
  logic [REG_W-1:0] periph_irq_enable_1_r;
  logic [REG_W-1:0] periph_irq_enable_2_r;
  logic [REG_W-1:0] periph_irq_enable_3_r;
  logic [REG_W-1:0] periph_irq_request_1_r;
  logic [REG_W-1:0] periph_irq_request_2_r;
  logic [REG_W-1:0] periph_irq_request_3_r;
  logic [REG_W-1:0] regctl_r;
  spdc_slpcfg_t slpcfg_r;
  logic timeout_flag_r;
  logic powerdown_flag_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic wdt_seen_r;
  logic master_clear_pin_evt;
  logic bor_evt;
  logic wdt_evt;
  logic full_rst_evt;
  logic pending;
  logic lp_eff;
  spdc_state_t state_r;
  spdc_state_t state_nxt;
  logic enter_sleep;
  logic nop_sleep;
  logic wake;
  logic core_off_nxt;
  logic [CW-1:0] settle_cnt_r;
  logic vector_pend_r;

  // the pin, the brownout comparator and the watchdog come from other clocks
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      wdt_seen_r <= 1'b0;
    end else begin
      sync1_r <= {I_WDT_TIMEOUT, I_BROWNOUT_RESET, ~I_MASTER_CLEAR_PIN_N};
      sync2_r <= sync1_r;
      wdt_seen_r <= sync2_r[2];
    end
  end

  // resets act in any state, so sleep never masks them
  assign master_clear_pin_evt = sync2_r[0];
  assign bor_evt = sync2_r[1];
  assign full_rst_evt = master_clear_pin_evt | bor_evt;
  assign wdt_evt = sync2_r[2] & ~wdt_seen_r;

  // wishbone classic: ack one cycle after the strobe, write commits on the ack edge
  assign wr_fire = I_WB_CYC & I_WB_STB & I_WB_WE & ack_r & I_WB_SEL[0];

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= I_WB_CYC & I_WB_STB & ~ack_r;
    end
  end

  // read mux; unmapped offsets read zero and still get an ack
  always_comb begin
    rd_byte = 8'h00;
    unique case (I_WB_ADR[WB_AW-1:2])
      OFS_INTCTL[WB_AW-1:2]: rd_byte = intctl_r;
      OFS_OPTION[WB_AW-1:2]: rd_byte = option_r;
      OFS_PERIPH_IRQ_ENABLE_1[WB_AW-1:2]: rd_byte = periph_irq_enable_1_r;
      OFS_PERIPH_IRQ_ENABLE_2[WB_AW-1:2]: rd_byte = periph_irq_enable_2_r;
      OFS_PERIPH_IRQ_ENABLE_3[WB_AW-1:2]: rd_byte = periph_irq_enable_3_r;
      OFS_PERIPH_IRQ_REQUEST_1[WB_AW-1:2]: rd_byte = periph_irq_request_1_r;
      OFS_PERIPH_IRQ_REQUEST_2[WB_AW-1:2]: rd_byte = periph_irq_request_2_r;
      OFS_PERIPH_IRQ_REQUEST_3[WB_AW-1:2]: rd_byte = periph_irq_request_3_r;
      OFS_REGCTL[WB_AW-1:2]: rd_byte = regctl_r;
      OFS_STATUS[WB_AW-1:2]: rd_byte = 8'(({7'h00, timeout_flag_r} << STAT_TO_BIT) |
                                            ({7'h00, powerdown_flag_r} << STAT_PD_BIT));
      OFS_SLPCFG[WB_AW-1:2]: rd_byte = slpcfg_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_DAT <= 32'h0;
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= I_WB_CYC & I_WB_STB & ~ack_r;
      O_WB_DAT <= (I_WB_CYC & I_WB_STB & ~ack_r & ~I_WB_WE) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // interrupt_control: hardware flag sets win over a software clear in the same cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      intctl_r <= RST_INTCTL;
    end else if (full_rst_evt) begin
      intctl_r <= RST_INTCTL;
    end else begin
      intctl_r <= (wr_hit(wr_fire, I_WB_ADR, OFS_INTCTL) ? I_WB_DAT[REG_W-1:0] : intctl_r) |
                  8'(({7'h00, I_TMR0_OVF} << INT_TMR0IF) | ({7'h00, I_EXT_INT} << INT_INTF) |
                     ({7'h00, I_IOC_EVT} << INT_IOCIF));
    end
  end

  // option and enable registers, plain storage
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      option_r <= RST_OPTION;
      periph_irq_enable_1_r <= RST_PIE;
      periph_irq_enable_2_r <= RST_PIE;
      periph_irq_enable_3_r <= RST_PIE;
    end else if (full_rst_evt) begin
      option_r <= RST_OPTION;
      periph_irq_enable_1_r <= RST_PIE;
      periph_irq_enable_2_r <= RST_PIE;
      periph_irq_enable_3_r <= RST_PIE;
    end else begin
      if (wr_hit(wr_fire, I_WB_ADR, OFS_OPTION)) begin
        option_r <= I_WB_DAT[REG_W-1:0];
      end
      if (wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_ENABLE_1)) begin
        periph_irq_enable_1_r <= I_WB_DAT[REG_W-1:0] & PERIPH_IRQ_REQUEST_1_MASK;
      end
      if (wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_ENABLE_2)) begin
        periph_irq_enable_2_r <= I_WB_DAT[REG_W-1:0] & PERIPH_IRQ_REQUEST_2_MASK;
      end
      if (wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_ENABLE_3)) begin
        periph_irq_enable_3_r <= I_WB_DAT[REG_W-1:0] & PERIPH_IRQ_REQUEST_3_MASK;
      end
    end
  end

  // request flags: set by peripherals regardless of enables, set beats clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      periph_irq_request_1_r <= RST_PIR;
      periph_irq_request_2_r <= RST_PIR;
      periph_irq_request_3_r <= RST_PIR;
    end else if (full_rst_evt) begin
      periph_irq_request_1_r <= RST_PIR;
      periph_irq_request_2_r <= RST_PIR;
      periph_irq_request_3_r <= RST_PIR;
    end else begin
      periph_irq_request_1_r <= ((wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_REQUEST_1) ? I_WB_DAT[REG_W-1:0] : periph_irq_request_1_r) | I_PERIPH_IRQ_REQUEST_1_SET) & PERIPH_IRQ_REQUEST_1_MASK;
      periph_irq_request_2_r <= ((wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_REQUEST_2) ? I_WB_DAT[REG_W-1:0] : periph_irq_request_2_r) | I_PERIPH_IRQ_REQUEST_2_SET) & PERIPH_IRQ_REQUEST_2_MASK;
      periph_irq_request_3_r <= ((wr_hit(wr_fire, I_WB_ADR, OFS_PERIPH_IRQ_REQUEST_3) ? I_WB_DAT[REG_W-1:0] : periph_irq_request_3_r) | I_PERIPH_IRQ_REQUEST_3_SET) & PERIPH_IRQ_REQUEST_3_MASK;
    end
  end

  // regulator control; bit 0 is reserved and should be kept set by software
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      regctl_r <= RST_REGCTL;
    end else if (full_rst_evt) begin
      regctl_r <= RST_REGCTL;
    end else if (wr_hit(wr_fire, I_WB_ADR, OFS_REGCTL)) begin
      regctl_r <= I_WB_DAT[REG_W-1:0] & REGCTL_MASK;
    end
  end

  // sleep configuration: watchdog mode, timer1 source, clock users
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      slpcfg_r <= spdc_slpcfg_t'(RST_SLPCFG);
    end else if (full_rst_evt) begin
      slpcfg_r <= spdc_slpcfg_t'(RST_SLPCFG);
    end else if (wr_hit(wr_fire, I_WB_ADR, OFS_SLPCFG)) begin
      slpcfg_r <= spdc_slpcfg_t'(I_WB_DAT[REG_W-1:0]);
    end
  end

  assign pending = irq_pending(intctl_r, periph_irq_enable_1_r, periph_irq_enable_2_r, periph_irq_enable_3_r, periph_irq_request_1_r, periph_irq_request_2_r, periph_irq_request_3_r);
  // the unregulated variant ignores the select bit and never settles
  assign lp_eff = REGULATED & regctl_r[REG_LP_BIT] & ~slpcfg_r.lp_blocker;

  // power state sequencing
  always_comb begin
    state_nxt = state_r;
    enter_sleep = 1'b0;
    nop_sleep = 1'b0;
    wake = 1'b0;
    unique case (state_r)
      ST_AWAKE: begin
        if (I_SLEEP_EXEC) begin
          if (pending && !intctl_r[INT_GIE]) begin
            nop_sleep = 1'b1;
          end else begin
            enter_sleep = 1'b1;
            state_nxt = ST_ASLEEP;
          end
        end
      end
      ST_ASLEEP: begin
        // a late interrupt still lets the entry complete, then wakes on the next edge
        if (pending || wdt_evt) begin
          wake = 1'b1;
          state_nxt = O_REG_LOW_POWER ? ST_SETTLE : ST_RESUME;
        end
      end
      ST_SETTLE: begin
        if (settle_cnt_r == '0) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        state_nxt = ST_AWAKE;
      end
    endcase
    if (full_rst_evt) begin
      state_nxt = ST_AWAKE;
    end
  end

  assign core_off_nxt = (state_nxt == ST_ASLEEP) || (state_nxt == ST_SETTLE);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= ST_AWAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // regulator settle delay counted from the wake edge
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      settle_cnt_r <= '0;
    end else if (wake) begin
      settle_cnt_r <= SETTLE_LOAD;
    end else if (state_r == ST_SETTLE && settle_cnt_r != '0) begin
      settle_cnt_r <= settle_cnt_r - 1'b1;
    end
  end

  // remember whether the wake should branch to the service routine
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      vector_pend_r <= 1'b0;
    end else if (full_rst_evt) begin
      vector_pend_r <= 1'b0;
    end else if (wake) begin
      vector_pend_r <= pending & intctl_r[INT_GIE];
    end
  end

  // timeout and powerdown flags; a no-op sleep leaves both untouched
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b1;
    end else if (bor_evt) begin
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b1;
    end else if (master_clear_pin_evt) begin
      timeout_flag_r <= timeout_flag_r;
    end else if (enter_sleep) begin
      timeout_flag_r <= 1'b1;
      powerdown_flag_r <= 1'b0;
    end else if (wdt_evt) begin
      timeout_flag_r <= 1'b0; // watchdog expiry, asleep or awake
    end
  end

  // core side handshakes
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CORE_CLK_EN <= 1'b1;
      O_PREFETCH_NEXT <= 1'b0;
      O_RESUME <= 1'b0;
      O_VECTOR_IRQ <= 1'b0;
      O_FULL_RESET <= 1'b0;
      O_IO_HOLD <= 1'b0;
    end else begin
      O_CORE_CLK_EN <= ~core_off_nxt;
      O_PREFETCH_NEXT <= enter_sleep | nop_sleep;
      O_RESUME <= (state_nxt == ST_RESUME) & ~full_rst_evt;
      // a fast wake resumes in the wake cycle itself, before vector_pend_r has caught up
      O_VECTOR_IRQ <= (state_nxt == ST_RESUME) & (wake ? pending & intctl_r[INT_GIE] : vector_pend_r) &
                      ~full_rst_evt;
      // an awake watchdog expiry resets; an asleep one only wakes
      O_FULL_RESET <= full_rst_evt | (wdt_evt & (state_r == ST_AWAKE));
      O_IO_HOLD <= core_off_nxt;
    end
  end

  // watchdog clear pulses and its run enable per mode
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WDT_CLEAR <= 1'b0;
      O_WDT_RUN <= 1'b0;
    end else begin
      O_WDT_CLEAR <= enter_sleep | wake;
      unique case (slpcfg_r.wdt_mode)
        WDT_ON: O_WDT_RUN <= 1'b1;
        WDT_NOT_SLEEP: O_WDT_RUN <= ~core_off_nxt;
        WDT_SW: O_WDT_RUN <= slpcfg_r.sw_wdt_en;
        WDT_OFF: O_WDT_RUN <= 1'b0;
      endcase
    end
  end

  // clock and regulator gating; peripherals stay clocked while the core runs
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_LFOSC_RUN <= 1'b1;
      O_HFOSC_RUN <= 1'b1;
      O_TIMER1_RUN <= 1'b1;
      O_ADC_RUN <= 1'b1;
      O_REG_LOW_POWER <= 1'b0;
    end else begin
      O_LFOSC_RUN <= 1'b1;
      O_HFOSC_RUN <= ~core_off_nxt | slpcfg_r.hfosc_user;
      O_TIMER1_RUN <= ~core_off_nxt | (slpcfg_r.t1_src == T1_PIN) | (slpcfg_r.t1_src == T1_LFOSC);
      O_ADC_RUN <= ~core_off_nxt | slpcfg_r.adc_rc_sel;
      // only in the asleep state; settle runs with the regulator back to normal
      O_REG_LOW_POWER <= (state_nxt == ST_ASLEEP) & lp_eff;
    end
  end

endmodule

// file: tb/spdc_core_model.sv
// behavioural core and interrupt sources facing the sleep controller
`timescale 1ns/100ps
module spdc_core_model (
  input wire logic i_clk,
  output logic o_sleep_exec,
  output logic [2:0] o_evt,
  output logic [7:0] o_periph_irq_request_1_set
);
  // quiet until the bench asks for something
  initial begin
    o_sleep_exec = 1'b0;
    o_evt = 3'h0;
    o_periph_irq_request_1_set = 8'h00;
  end
  // one-cycle sleep instruction, launched just after an edge
  task automatic do_sleep();
    o_sleep_exec <= 1'b1;
    @(posedge i_clk);
    o_sleep_exec <= 1'b0;
  endtask
  // one-cycle event: bit 2 timer0, bit 1 external pin, bit 0 pin change, plus request set bits
  task automatic fire(input logic [2:0] e, input logic [7:0] p);
    o_evt <= e;
    o_periph_irq_request_1_set <= p;
    @(posedge i_clk);
    o_evt <= 3'h0;
    o_periph_irq_request_1_set <= 8'h00;
  endtask
endmodule

// file: tb/spdc_sleep_checker.sv
// port-level assertions of the sleep power-down controller
`timescale 1ns/100ps
module spdc_sleep_checker
  import spdc_pkg::*;
#(
  parameter bit REGULATED = 1'b1,
  parameter int SETTLE_CNT = SETTLE_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_SLEEP_EXEC,
  input wire logic O_CORE_CLK_EN,
  input wire logic O_PREFETCH_NEXT,
  input wire logic O_RESUME,
  input wire logic O_VECTOR_IRQ,
  input wire logic O_FULL_RESET,
  input wire logic O_WDT_CLEAR,
  input wire logic O_LFOSC_RUN,
  input wire logic O_IO_HOLD,
  input wire logic O_REG_LOW_POWER
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // sleep instruction met by a running core, resume cycle excluded since it is ignored there
  sequence sleep_taken;
    I_SLEEP_EXEC && O_CORE_CLK_EN && !O_RESUME && !O_FULL_RESET;
  endsequence
  // regulator leaves low power outside any reset
  sequence lp_release;
    $fell(O_REG_LOW_POWER) && !O_FULL_RESET;
  endsequence
  prefetch_after_a: assert property (sleep_taken |=> O_PREFETCH_NEXT)
    else $error("no prefetch after sleep");
  entry_clear_a: assert property ($fell(O_CORE_CLK_EN) |-> O_WDT_CLEAR && O_IO_HOLD)
    else $error("sleep entry without watchdog clear");
  sleep_cause_a: assert property ($fell(O_CORE_CLK_EN) |-> $past(I_SLEEP_EXEC))
    else $error("core clock stopped without sleep");
  core_gated_a: assert property (!O_CORE_CLK_EN |-> O_IO_HOLD && !O_RESUME)
    else $error("pins released while core stopped");
  lfosc_on_a: assert property (O_LFOSC_RUN)
    else $error("low frequency oscillator stopped");
  lp_asleep_a: assert property (O_REG_LOW_POWER |-> REGULATED && !O_CORE_CLK_EN && O_IO_HOLD)
    else $error("low power outside sleep");
  vector_resume_a: assert property (O_VECTOR_IRQ |-> O_RESUME && O_CORE_CLK_EN)
    else $error("vector without resume");
  resume_once_a: assert property (O_RESUME |=> !O_RESUME)
    else $error("resume longer than one cycle");
  wake_clear_a: assert property (lp_release |-> O_WDT_CLEAR)
    else $error("low power wake without watchdog clear");
  settle_wait_a: assert property (lp_release |-> !O_CORE_CLK_EN [*2] ##[1:1000] O_RESUME)
    else $error("low power wake skipped settling");
  resume_clock_a: assert property ($rose(O_CORE_CLK_EN) && !O_FULL_RESET |-> O_RESUME)
    else $error("core restarted without resume");
endmodule
bind spdc_sleep_ctrl spdc_sleep_checker #(.REGULATED(REGULATED), .SETTLE_CNT(SETTLE_CNT)) chk_i (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_SLEEP_EXEC(I_SLEEP_EXEC), .O_CORE_CLK_EN(O_CORE_CLK_EN),
  .O_PREFETCH_NEXT(O_PREFETCH_NEXT), .O_RESUME(O_RESUME), .O_VECTOR_IRQ(O_VECTOR_IRQ),
  .O_FULL_RESET(O_FULL_RESET), .O_WDT_CLEAR(O_WDT_CLEAR), .O_LFOSC_RUN(O_LFOSC_RUN),
  .O_IO_HOLD(O_IO_HOLD), .O_REG_LOW_POWER(O_REG_LOW_POWER)
);

// file: tb/spdc_sleep_ctrl_tb.sv
// self-checking bench of the sleep power-down controller
`timescale 1ns/100ps
module spdc_sleep_ctrl_tb
  import spdc_pkg::*;
;
  localparam int SC = 3;
  logic clk, rst, cyc, stb, we, bor, wdt, ack, sleep_exec, clk_en, prefetch, resume, vector, full_rst;
  logic wdt_clr, wdt_run, lfosc, hfosc, t1_run, adc_run, io_hold, reg_lp, master_clear_pin_n;
  logic [WB_AW-1:0] adr;
  logic [WB_DW-1:0] wdat, rdat, q;
  logic [2:0] evt;
  logic [REG_W-1:0] periph_irq_request_1;
  int mismatches, n_compared, cycles, n;
  // short settle count keeps the low-power wake visible without long waits
  spdc_sleep_ctrl #(.REGULATED(1'b1), .SETTLE_CNT(SC)) uut (
    .I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_DAT(wdat), .I_WB_SEL(4'hf), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SLEEP_EXEC(sleep_exec),
    .I_TMR0_OVF(evt[2]), .I_EXT_INT(evt[1]), .I_IOC_EVT(evt[0]), .I_PERIPH_IRQ_REQUEST_1_SET(periph_irq_request_1), .I_PERIPH_IRQ_REQUEST_2_SET(8'h00),
    .I_PERIPH_IRQ_REQUEST_3_SET(8'h00), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n), .I_BROWNOUT_RESET(bor), .I_WDT_TIMEOUT(wdt),
    .O_CORE_CLK_EN(clk_en), .O_PREFETCH_NEXT(prefetch), .O_RESUME(resume), .O_VECTOR_IRQ(vector),
    .O_FULL_RESET(full_rst), .O_WDT_CLEAR(wdt_clr), .O_WDT_RUN(wdt_run), .O_LFOSC_RUN(lfosc),
    .O_HFOSC_RUN(hfosc), .O_TIMER1_RUN(t1_run), .O_ADC_RUN(adc_run), .O_IO_HOLD(io_hold),
    .O_REG_LOW_POWER(reg_lp)
  );
  spdc_core_model core (.i_clk(clk), .o_sleep_exec(sleep_exec), .o_evt(evt), .o_periph_irq_request_1_set(periph_irq_request_1));
  // 10 mhz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [WB_DW-1:0] got, input logic [WB_DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic see(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // classic cycle: hold until ack is sampled, take data there, then idle one cycle
  task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [REG_W-1:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    see(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [WB_AW-1:0] a, input logic [REG_W-1:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // sleep pulse, then the first cycle after it; exp_on high means a no-op
  task automatic enter(input logic exp_on);
    core.do_sleep();
    @(negedge clk);
    see(prefetch, 1'b1);
    see(clk_en, exp_on);
    see(wdt_clr, !exp_on);
    see(io_hold, !exp_on);
    see(lfosc, 1'b1);
    @(posedge clk);
  endtask
  // waits for the resume pulse and checks what comes with it and how soon
  task automatic wake(input logic v, input int lo, input int hi, input logic c);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resume !== 1'b1 && n < 40);
    see(resume, 1'b1);
    see(vector, v);
    see(wdt_clr, c);
    see(clk_en, 1'b1);
    chk(32'(n >= lo && n <= hi), 32'h1);
    @(posedge clk);
  endtask
  initial begin
    rst = 1'b1;
    {cyc, stb, we, bor, wdt} = 5'h0;
    master_clear_pin_n = 1'b1;
    adr = '0;
    wdat = '0;
    {mismatches, n_compared, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_OPTION, RST_OPTION);
    rd(OFS_REGCTL, RST_REGCTL);
    rd(OFS_STATUS, 8'h18);
    wb(1'b1, 8'h3c, 8'h55);
    rd(8'h3c, 8'h00);
    wb(1'b1, OFS_REGCTL, 8'hff);
    rd(OFS_REGCTL, REGCTL_MASK);
    wb(1'b1, OFS_REGCTL, RST_REGCTL);
    $display("registers done");
    // only the external pin is enabled; a timer0 event must not wake
    wb(1'b1, OFS_INTCTL, 8'h10);
    enter(1'b0);
    @(negedge clk);
    see(t1_run, 1'b0);
    see(adc_run, 1'b0);
    see(reg_lp, 1'b0);
    @(posedge clk);
    rd(OFS_STATUS, 8'h10);
    core.fire(3'b100, 8'h00);
    repeat (4) @(posedge clk);
    @(negedge clk);
    see(clk_en, 1'b0);
    @(posedge clk);
    core.fire(3'b010, 8'h00);
    wake(1'b0, 1, 4, 1'b1);
    // flag left pending with global enable off: sleep must do nothing
    enter(1'b1);
    rd(OFS_STATUS, 8'h10);
    // pending with global enable on: sleep completes, wakes at once and vectors
    wb(1'b1, OFS_INTCTL, 8'h92);
    enter(1'b0);
    wake(1'b1, 1, 2, 1'b1);
    rd(OFS_STATUS, 8'h10);
    $display("interrupt wake done");
    // low-power sleep, then the same with an incompatible peripheral active
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, OFS_INTCTL, 8'h10);
      wb(1'b1, OFS_REGCTL, 8'h03);
      wb(1'b1, OFS_SLPCFG, (i != 0) ? 8'h80 : 8'h00);
      enter(1'b0);
      @(negedge clk);
      see(reg_lp, i == 0);
      @(posedge clk);
      core.fire(3'b010, 8'h00);
      wake(1'b0, (i != 0) ? 1 : SC + 2, (i != 0) ? 4 : SC + 6, i != 0);
    end
    $display("low power done");
    // peripheral request wake needs its enable and the peripheral enable
    wb(1'b1, OFS_REGCTL, RST_REGCTL);
    wb(1'b1, OFS_INTCTL, 8'h40);
    wb(1'b1, OFS_PERIPH_IRQ_ENABLE_1, 8'h01);
    enter(1'b0);
    core.fire(3'b000, 8'h01);
    wake(1'b0, 1, 4, 1'b1);
    // clocks kept for sleep-capable users, then a watchdog wake
    wb(1'b1, OFS_PERIPH_IRQ_REQUEST_1, 8'h00);
    wb(1'b1, OFS_SLPCFG, 8'h75);
    enter(1'b0);
    @(negedge clk);
    see(t1_run, 1'b1);
    see(adc_run, 1'b1);
    see(hfosc, 1'b1);
    see(wdt_run, 1'b1);
    @(posedge clk);
    wdt <= 1'b1;
    wake(1'b0, 1, 10, 1'b1);
    wdt <= 1'b0;
    rd(OFS_STATUS, 8'h00);
    $display("peripheral and watchdog wake done");
    // master clear keeps both flags, brownout sets them; both restore the config
    for (int i = 0; i < 2; i++) begin
      {master_clear_pin_n, bor} <= (i != 0) ? 2'b11 : 2'b00;
      repeat (4) @(posedge clk);
      @(negedge clk);
      see(full_rst, 1'b1);
      @(posedge clk);
      {master_clear_pin_n, bor} <= 2'b10;
      repeat (4) @(posedge clk);
      rd(OFS_STATUS, (i != 0) ? 8'h18 : 8'h00);
      rd(OFS_SLPCFG, RST_SLPCFG);
    end
    $display("master clear and brownout done");
    conclude();
  end
endmodule
